// >>> hw/vco_ctrl.sv
// Purpose: loop control, oscillator calibration and output control.
// Assumes: ticks and compare inputs are synchronous to clk_in.
// Notes:   band search compares once per settle window.
`timescale 1ns/1ps
`include "vco_regs.svh"

module vco_ctrl (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  // Register port
  input  wire logic [4:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Loop ticks
  input  wire logic        ref_tick_in,
  input  wire logic        vco_tick_in,
  // Calibration frequency compare
  input  wire logic        cal_slow_in,
  input  wire logic        cal_fast_in,
  // Buffer enable pin
  input  wire logic        buffer_enable_pin_in,
  // Charge pump
  output logic             pump_up_out,
  output logic             pump_down_out,
  output logic      [4:0]  cp_gain_out,
  // Oscillator
  output logic      [1:0]  core_out,
  output logic      [7:0]  band_code_out,
  output logic             cal_busy_out,
  // RF outputs
  output logic             rf_a_tick_out,
  output logic             rf_b_tick_out,
  output logic             out_a_enable_out,
  output logic             out_b_enable_out,
  output logic      [5:0]  out_a_level_out,
  output logic      [5:0]  out_b_level_out
);

  // Even divide values 2..38 only
  function automatic logic div_ok(input logic [5:0] v);
    div_ok = (v >= `OUTPUT_DIVIDE_VALUE_MIN) && (v <= `OUTPUT_DIVIDE_VALUE_MAX) && !v[0];
  endfunction

  // Buffer power state from power-down, override and pin
  function automatic logic buf_on(input logic pd, input logic ovr, input logic pin);
    buf_on = !pd && (!ovr || pin);
  endfunction

  logic [31:0] freq_q;
  logic [31:0] pll_q;
  logic [31:0] cal_q;
  logic [31:0] out_q;
  logic        cal_start;
  logic [31:0] stat;

  vco_pkg::vco_cal_state_t state_q;
  logic [1:0]  core_q;
  logic [7:0]  band_q;
  logic [1:0]  last_core_q;
  logic        done_q;
  logic        fail_q;
  logic [3:0]  settle_q;

  logic [7:0]  rcnt_q;
  logic [8:0]  rsum;
  logic [7:0]  rdiv;
  logic        ref_pulse;
  logic [15:0] ncnt_q;
  logic [15:0] ndiv;
  logic        fb_tick;
  logic        fb_pulse;
  logic [5:0]  ocnt_q;
  logic        div_pulse;
  logic [2:0]  on_cnt_q;

  // Field views
  wire         zero_dly = out_q[`VCO_ZD_BIT];
  wire  [5:0]  div_val  = out_q[`OUTPUT_DIVIDE_VALUE_MSB:`OUTPUT_DIVIDE_VALUE_LSB];
  wire  [2:0]  min_on   = pll_q[`VCO_DLY_MSB:`VCO_DLY_LSB];

  // Register zero write starts calibration unless skipped
  assign cal_start = wr_in && (addr_in == `VCO_A_FREQ)
                     && !wdata_in[`VCO_SKIP_BIT];

  // Register writes; illegal divide values keep old divide
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      freq_q <= `VCO_RST_FREQ;
      pll_q  <= `VCO_RST_PLL;
      cal_q  <= `VCO_RST_CAL;
      out_q  <= `VCO_RST_OUT;
    end else if (ce_in && wr_in) begin
      case (addr_in)
        `VCO_A_FREQ: freq_q <= wdata_in;
        `VCO_A_PLL:  pll_q  <= wdata_in;
        `VCO_A_CAL:  cal_q  <= wdata_in;
        `VCO_A_OUT: begin
          out_q <= wdata_in;
          if (!div_ok(wdata_in[`OUTPUT_DIVIDE_VALUE_MSB:`OUTPUT_DIVIDE_VALUE_LSB])) begin
            out_q[`OUTPUT_DIVIDE_VALUE_MSB:`OUTPUT_DIVIDE_VALUE_LSB] <= div_val;
          end
        end
        default: ;
      endcase
    end
  end

  // Status word
  always_comb begin
    stat = 32'h0000_0000;
    stat[`VCO_ST_BUSY_BIT] = (state_q != vco_pkg::VCO_IDLE);
    stat[`VCO_ST_DONE_BIT] = done_q;
    stat[`VCO_ST_FAIL_BIT] = fail_q;
    stat[`VCO_ST_CORE_MSB:`VCO_ST_CORE_LSB] = core_q;
    stat[`VCO_ST_BAND_MSB:`VCO_ST_BAND_LSB] = band_q;
    stat[`VCO_ST_LAST_MSB:`VCO_ST_LAST_LSB] = last_core_q;
  end

  // Read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      if (rd_in) begin
        case (addr_in)
          `VCO_A_FREQ: rdata_out <= freq_q;
          `VCO_A_PLL:  rdata_out <= pll_q;
          `VCO_A_CAL:  rdata_out <= cal_q;
          `VCO_A_OUT:  rdata_out <= out_q;
          `VCO_A_STAT: rdata_out <= stat;
          default:     rdata_out <= 32'h0000_0000;
        endcase
      end else begin
        rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Reference divider; doubler adds two per tick
  assign rdiv = (pll_q[`VCO_R_MSB:`VCO_R_LSB] == 8'h00) ? 8'h01
                : pll_q[`VCO_R_MSB:`VCO_R_LSB];
  assign rsum = {1'b0, rcnt_q}
                + (pll_q[`VCO_DBL_BIT] ? 9'h002 : 9'h001);
  assign ref_pulse = ref_tick_in && (rsum >= {1'b0, rdiv});

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rcnt_q <= 8'h00;
    end else if (ce_in && ref_tick_in) begin
      rcnt_q <= ref_pulse ? 8'(rsum - {1'b0, rdiv}) : rsum[7:0];
    end
  end

  // Output divider counts oscillator ticks; compare is >= so a smaller divide never wraps the counter
  assign div_pulse = vco_tick_in && (ocnt_q >= 6'(div_val - 6'h01));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ocnt_q <= 6'h00;
    end else if (ce_in && vco_tick_in) begin
      ocnt_q <= div_pulse ? 6'h00 : 6'(ocnt_q + 6'h01);
    end
  end

  // Divider enters feedback only in zero-delay mode
  assign fb_tick = zero_dly ? div_pulse : vco_tick_in;
  assign ndiv = (freq_q[`VCO_N_MSB:`VCO_N_LSB] == 16'h0000) ? 16'h0001
                : freq_q[`VCO_N_MSB:`VCO_N_LSB];
  assign fb_pulse = fb_tick && (ncnt_q >= 16'(ndiv - 16'h0001));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ncnt_q <= 16'h0000;
    end else if (ce_in && fb_tick) begin
      ncnt_q <= fb_pulse ? 16'h0000 : 16'(ncnt_q + 16'h0001);
    end
  end

  // Phase detector; both sides held at least the set on time
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pump_up_out   <= 1'b0;
      pump_down_out <= 1'b0;
      on_cnt_q      <= 3'h0;
    end else if (ce_in) begin
      if (pump_up_out && pump_down_out) begin
        if (on_cnt_q >= min_on) begin
          pump_up_out   <= ref_pulse;
          pump_down_out <= fb_pulse;
          on_cnt_q      <= 3'h0;
        end else begin
          on_cnt_q <= 3'(on_cnt_q + 3'h1);
        end
      end else begin
        pump_up_out   <= pump_up_out | ref_pulse;
        pump_down_out <= pump_down_out | fb_pulse;
      end
    end
  end

  // Charge pump gain, 32 levels
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cp_gain_out <= 5'h00;
    end else if (ce_in) begin
      cp_gain_out <= pll_q[`VCO_CPG_MSB:`VCO_CPG_LSB];
    end
  end

  // Calibration; a new start restarts any search in progress
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q     <= vco_pkg::VCO_IDLE;
      core_q      <= `VCO_CORE_LO;
      band_q      <= `VCO_BAND_LO;
      last_core_q <= `VCO_CORE_LO;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      settle_q    <= 4'h0;
    end else if (ce_in) begin
      if (cal_start) begin
        // Start core by policy, band from default code
        core_q   <= wdata_in[`VCO_SKIP_BIT] ? core_q
                  : (cal_q[`VCO_CPOL_BIT] ? cal_q[`VCO_CSEL_MSB:`VCO_CSEL_LSB]
                  : last_core_q);
        band_q   <= cal_q[`VCO_BAND_MSB:`VCO_BAND_LSB];
        done_q   <= 1'b0;
        fail_q   <= 1'b0;
        settle_q <= 4'h0;
        state_q  <= vco_pkg::VCO_SETTLE;
      end else begin
        case (state_q)
          vco_pkg::VCO_IDLE: ; // Band code held
          vco_pkg::VCO_SETTLE: begin
            // Let the compare settle after each band change
            if (settle_q == 4'(`VCO_SETTLE_CYC - 1)) begin
              state_q <= vco_pkg::VCO_STEP;
            end else begin
              settle_q <= 4'(settle_q + 4'h1);
            end
          end
          vco_pkg::VCO_STEP: begin
            settle_q <= 4'h0;
            state_q  <= vco_pkg::VCO_SETTLE;
            if (!cal_slow_in && !cal_fast_in) begin
              done_q      <= 1'b1;
              last_core_q <= core_q;
              state_q     <= vco_pkg::VCO_IDLE;
            end else if (cal_slow_in && band_q != `VCO_BAND_LO) begin
              band_q <= 8'(band_q - 8'h01); // lower code, higher freq
            end else if (cal_fast_in && band_q != `VCO_BAND_HI) begin
              band_q <= 8'(band_q + 8'h01);
            end else if (cal_slow_in && core_q != `VCO_CORE_HI) begin
              core_q <= 2'(core_q + 2'h1); // faster core
              band_q <= cal_q[`VCO_BAND_MSB:`VCO_BAND_LSB];
            end else if (cal_fast_in && !cal_slow_in && core_q != `VCO_CORE_LO) begin
              core_q <= 2'(core_q - 2'h1); // slower core
              band_q <= cal_q[`VCO_BAND_MSB:`VCO_BAND_LSB];
            end else begin
              fail_q  <= 1'b1; // no core left
              state_q <= vco_pkg::VCO_IDLE;
            end
          end
          default: state_q <= vco_pkg::VCO_IDLE;
        endcase
      end
    end
  end

  // Oscillator core and band drive, 255 is slowest band
  assign core_out      = core_q;
  assign band_code_out = band_q;
  assign cal_busy_out  = (state_q != vco_pkg::VCO_IDLE);

  // RF output ticks, buffer states and levels
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rf_a_tick_out    <= 1'b0;
      rf_b_tick_out    <= 1'b0;
      out_a_enable_out <= 1'b0;
      out_b_enable_out <= 1'b0;
      out_a_level_out  <= 6'h00;
      out_b_level_out  <= 6'h00;
    end else if (ce_in) begin
      rf_a_tick_out <= out_q[`VCO_BYPA_BIT] ? vco_tick_in : div_pulse;
      rf_b_tick_out <= out_q[`VCO_BYPB_BIT] ? vco_tick_in : div_pulse;
      out_a_enable_out <= buf_on(out_q[`VCO_PDA_BIT], out_q[`VCO_OVR_BIT],
                                 buffer_enable_pin_in);
      out_b_enable_out <= buf_on(out_q[`VCO_PDB_BIT], out_q[`VCO_OVR_BIT],
                                 buffer_enable_pin_in);
      out_a_level_out <= out_q[`VCO_PWRA_MSB:`VCO_PWRA_LSB];
      out_b_level_out <= out_q[`VCO_PWRB_MSB:`VCO_PWRB_LSB];
    end
  end

endmodule

// >>> hw/vco_regs.svh
// Purpose: register map, fields, reset values and timing of the synthesizer control.
// Assumes: 5-bit word-aligned byte addresses, 32-bit data.
// Notes:   fields are bit positions inside their register word.
`ifndef VCO_CTRL_REGS_SVH
`define VCO_CTRL_REGS_SVH

// Register addresses
`define VCO_A_FREQ  5'h00
`define VCO_A_PLL   5'h04
`define VCO_A_CAL   5'h08
`define VCO_A_OUT   5'h0C
`define VCO_A_STAT  5'h10

// Reset values
`define VCO_RST_FREQ 32'h0001_0064
`define VCO_RST_PLL  32'h0000_0001
`define VCO_RST_CAL  32'h0000_0406
`define VCO_RST_OUT  32'h0000_0602

// Frequency control register
`define VCO_N_MSB    15
`define VCO_N_LSB    0
`define VCO_SKIP_BIT 16
// Loop register
`define VCO_R_MSB    7
`define VCO_R_LSB    0
`define VCO_DBL_BIT  8
`define VCO_CPG_MSB  13
`define VCO_CPG_LSB  9
`define VCO_DLY_MSB  16
`define VCO_DLY_LSB  14
// Calibration register
`define VCO_CSEL_MSB 1
`define VCO_CSEL_LSB 0
`define VCO_CPOL_BIT 2
`define VCO_BAND_MSB 10
`define VCO_BAND_LSB 3
`define VCO_RFS_MSB  18
`define VCO_RFS_LSB  11
// Output register
`define OUTPUT_DIVIDE_VALUE_MSB  5
`define OUTPUT_DIVIDE_VALUE_LSB  0
`define VCO_ZD_BIT   6
`define VCO_BYPA_BIT 7
`define VCO_BYPB_BIT 8
`define VCO_PDA_BIT  9
`define VCO_PDB_BIT  10
`define VCO_OVR_BIT  11
`define VCO_PWRA_MSB 17
`define VCO_PWRA_LSB 12
`define VCO_PWRB_MSB 23
`define VCO_PWRB_LSB 18
// Status register
`define VCO_ST_BUSY_BIT 0
`define VCO_ST_DONE_BIT 1
`define VCO_ST_FAIL_BIT 2
`define VCO_ST_CORE_MSB 4
`define VCO_ST_CORE_LSB 3
`define VCO_ST_BAND_MSB 12
`define VCO_ST_BAND_LSB 5
`define VCO_ST_LAST_MSB 14
`define VCO_ST_LAST_LSB 13

// Limits
`define OUTPUT_DIVIDE_VALUE_MIN  6'h02
`define OUTPUT_DIVIDE_VALUE_MAX  6'h26
`define VCO_BAND_LO  8'h00
`define VCO_BAND_HI  8'hFF
`define VCO_CORE_LO  2'h0
`define VCO_CORE_HI  2'h3

// Timing
`define VCO_CLK_NS    4
`define VCO_SETTLE_NS 40
`define VCO_SETTLE_CYC ((`VCO_SETTLE_NS + `VCO_CLK_NS - 1) / `VCO_CLK_NS)

`endif

// >>> hw/vco_pkg.sv
// Purpose: shared types of the synthesizer control.
// Assumes: nothing beyond the register header.
// Notes:   calibration walks these states.
package vco_pkg;
  typedef enum logic [1:0] {
    VCO_IDLE,
    VCO_SETTLE,
    VCO_STEP
  } vco_cal_state_t;
endpackage

// >>> bench/vco_osc_model.sv
// Purpose: oscillator compare model answering the band search.
// Assumes: rank = core * 256 + (255 - band).
// Notes:   levels lag the code one clock, as a counter would.
`timescale 1ns/1ps
module vco_osc_model (
  // Clock and code
  input  wire logic        clk_in,
  input  wire logic [1:0]  core_in,
  input  wire logic [7:0]  band_in,
  input  wire logic [10:0] target_in,
  // Compare levels
  output logic             slow_out,
  output logic             fast_out
);
  logic [9:0] rank;
  // Code 255 lowest, higher core faster
  assign rank = {core_in, ~band_in};
  // Registered compare, both low on match
  always_ff @(posedge clk_in) begin
    slow_out <= rank < target_in;
    fast_out <= rank > target_in;
  end
endmodule

// >>> bench/vco_ctrl_properties.sv
// Purpose: port properties of the synthesizer control.
// Assumes: ce_in stays high while steps are timed.
// Notes:   search checks skip cycles after a write, which may restart it.
`timescale 1ns/1ps
`include "vco_regs.svh"
module vco_ctrl_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        resetn_in,
  // Register port
  input wire logic        ce_in,
  input wire logic [4:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // Design outputs
  input wire logic        pump_up_out,
  input wire logic        pump_down_out,
  input wire logic [4:0]  cp_gain_out,
  input wire logic [1:0]  core_out,
  input wire logic [7:0]  band_code_out,
  input wire logic        cal_busy_out,
  input wire logic        out_a_enable_out
);
  logic f_wr;
  logic o_wr;
  // Decoded writes
  assign f_wr = ce_in && wr_in && addr_in == `VCO_A_FREQ;
  assign o_wr = ce_in && wr_in && addr_in == `VCO_A_OUT;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  chk_read_idle: assert property (ce_in && !rd_in |=> rdata_out == 32'h0)
    else $error("read data not cleared");
  chk_bad_addr: assert property (ce_in && rd_in && (addr_in[1:0] != 2'h0 || addr_in > `VCO_A_STAT)
    |=> rdata_out == 32'h0) else $error("unmapped read not zero");
  chk_cal_start: assert property (f_wr && !wdata_in[`VCO_SKIP_BIT] |=> cal_busy_out)
    else $error("calibration not started");
  chk_skip_idle: assert property (f_wr && wdata_in[`VCO_SKIP_BIT] && !cal_busy_out |=> !cal_busy_out)
    else $error("skip write started calibration");
  chk_idle_hold: assert property (!cal_busy_out && !f_wr |=> $stable(band_code_out) && $stable(core_out))
    else $error("code moved while idle");
  chk_settle_wait: assert property ($rose(cal_busy_out) |=> $stable(band_code_out) [*8])
    else $error("band moved during settle");
  chk_step_one: assert property (cal_busy_out && $past(cal_busy_out) && !$past(wr_in) && $stable(core_out)
    && $changed(band_code_out) |-> (band_code_out - $past(band_code_out) == 8'h01)
    || (band_code_out - $past(band_code_out) == 8'hFF)) else $error("band step not one");
  chk_gain_copy: assert property (ce_in && wr_in && addr_in == `VCO_A_PLL ##1 ce_in
    |=> cp_gain_out == $past(wdata_in[`VCO_CPG_MSB:`VCO_CPG_LSB], 2)) else $error("gain not applied");
  chk_pd_off: assert property (o_wr && wdata_in[`VCO_PDA_BIT] ##1 !o_wr |=> !out_a_enable_out)
    else $error("output a not powered down");
  chk_pd_on: assert property (o_wr && !wdata_in[`VCO_PDA_BIT] && !wdata_in[`VCO_OVR_BIT] ##1 !o_wr
    |=> out_a_enable_out) else $error("output a not powered up");
  chk_pump_min: assert property (pump_up_out && pump_down_out |-> ##[1:9] !(pump_up_out && pump_down_out))
    else $error("pump pulses overlap too long");
endmodule

bind vco_ctrl vco_ctrl_chk u_vco_ctrl_chk (.clk_in, .resetn_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .pump_up_out, .pump_down_out, .cp_gain_out, .core_out, .band_code_out, .cal_busy_out,
  .out_a_enable_out);

// >>> bench/vco_ctrl_test.sv
// Purpose: register-level tests of the synthesizer control.
// Assumes: ce_in high but for one frozen write; oscillator ticks every clock.
// Notes:   the oscillator model answers the band search.
`timescale 1ns/1ps
`include "vco_regs.svh"
module vco_ctrl_test;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ref_tick = 1'b0;
  logic        pin = 1'b0;
  logic        ce = 1'b1;
  logic        dn_prev;
  logic [10:0] target = 11'h000;
  logic [31:0] rdata;
  logic        slow, fast, up, dn, busy, tk_a, tk_b, en_a, en_b;
  logic [4:0]  gain;
  logic [1:0]  core;
  logic [7:0]  band;
  logic [5:0]  lv_a, lv_b;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cnt_a, cnt_b, cnt_d;
  logic [7:0]  bad [4] = '{8'h05, 8'h28, 8'h00, 8'h03};
  // Clock and reference ticks
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) ref_tick <= ~ref_tick;
  vco_ctrl u_vco_ctrl (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ref_tick_in(ref_tick),
    .vco_tick_in(1'b1), .cal_slow_in(slow), .cal_fast_in(fast), .buffer_enable_pin_in(pin),
    .pump_up_out(up), .pump_down_out(dn), .cp_gain_out(gain), .core_out(core),
    .band_code_out(band), .cal_busy_out(busy), .rf_a_tick_out(tk_a), .rf_b_tick_out(tk_b),
    .out_a_enable_out(en_a), .out_b_enable_out(en_b), .out_a_level_out(lv_a), .out_b_level_out(lv_b));
  vco_osc_model u_vco_osc_model (.clk_in(clk_in), .core_in(core), .band_in(band),
    .target_in(target), .slow_out(slow), .fast_out(fast));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    check(rdata, exp);
  endtask
  task automatic count(input int n);
    cnt_a = 0;
    cnt_b = 0;
    cnt_d = 0;
    repeat (12) @(negedge clk_in);
    dn_prev = dn;
    repeat (n) begin
      @(negedge clk_in);
      cnt_a += tk_a;
      cnt_b += tk_b;
      cnt_d += (dn & ~dn_prev);
      dn_prev = dn;
    end
  endtask
  task automatic cal_run(input logic [31:0] cw, input logic [10:0] t, input logic [9:0] s, input logic [31:0] st);
    @(posedge clk_in);
    target <= t;
    wr_reg(`VCO_A_CAL, cw);
    wr_reg(`VCO_A_FREQ, 32'h0000_0064);
    @(negedge clk_in);
    check(busy, 1'b1);
    check({core, band}, s);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk_in);
    rc(`VCO_A_STAT, st);
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    rc(`VCO_A_FREQ, `VCO_RST_FREQ);
    rc(`VCO_A_PLL, `VCO_RST_PLL);
    rc(`VCO_A_CAL, `VCO_RST_CAL);
    rc(`VCO_A_OUT, `VCO_RST_OUT);
    check({en_a, en_b}, 2'h0);
    wr_reg(5'h14, 32'hFFFF_FFFF);
    wr_reg(`VCO_A_STAT, 32'hFFFF_FFFF);
    rc(5'h14, 32'h0);
    rc(`VCO_A_STAT, 32'h0);
    $display("reset test done");
    for (int g = 0; g < 32; g++) begin
      wr_reg(`VCO_A_PLL, 32'(g) << 9 | 32'h1);
      repeat (2) @(negedge clk_in);
      check(gain, g[4:0]);
    end
    wr_reg(`VCO_A_PLL, 32'h0001_7F05);
    rc(`VCO_A_PLL, 32'h0001_7F05);
    $display("loop test done");
    // Power state table: override, power-down, pin
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      pin <= i[0];
      wr_reg(`VCO_A_OUT, {20'h0, i[2], i[1], i[1], 9'h006});
      repeat (3) @(negedge clk_in);
      check({en_a, en_b}, {2{~i[1] & (~i[2] | i[0])}});
    end
    wr_reg(`VCO_A_OUT, 32'h0051_E106);
    count(60);
    check(lv_a, 6'h1E);
    check(lv_b, 6'h14);
    check(cnt_a, 10);
    check(cnt_b, 60);
    foreach (bad[i]) begin
      wr_reg(`VCO_A_OUT, 32'h00A8_0100 | bad[i]);
      rc(`VCO_A_OUT, 32'h00A8_0106);
    end
    wr_reg(`VCO_A_OUT, 32'h00A8_0126);
    rc(`VCO_A_OUT, 32'h00A8_0126);
    count(76);
    check(cnt_a, 2);
    wr_reg(`VCO_A_OUT, 32'h0000_0102);
    wr_reg(`VCO_A_OUT, 32'h0000_0106);
    wr_reg(`VCO_A_OUT, 32'h0000_0104);
    count(40);
    check(cnt_a, 10);
    $display("output test done");
    cal_run(32'h0003_2405, 11'h17C, 10'h180, 32'h0000_306A);
    cal_run(32'h0003_2405, 11'h258, 10'h180, 32'h0000_54F2);
    cal_run(32'h0003_2400, 11'h27F, 10'h280, 32'h0000_5012);
    cal_run(32'h0003_2027, 11'h7FF, 10'h304, 32'h0000_401C);
    wr_reg(`VCO_A_FREQ, 32'h0001_0064);
    @(negedge clk_in);
    check(busy, 1'b0);
    check({core, band}, 10'h300);
    rc(`VCO_A_FREQ, 32'h0001_0064);
    $display("calibration test done");
    // Feedback rate before and after zero-delay entry must match
    wr_reg(`VCO_A_FREQ, 32'h0001_0018);
    count(240);
    check(cnt_d, 10);
    wr_reg(`VCO_A_OUT, 32'h0000_0144);
    wr_reg(`VCO_A_FREQ, 32'h0001_0006);
    count(240);
    check(cnt_d, 10);
    rc(`VCO_A_OUT, 32'h0000_0144);
    // Clock enable low drops a calibration write
    @(posedge clk_in);
    ce <= 1'b0;
    wr_reg(`VCO_A_FREQ, 32'h0000_0030);
    @(negedge clk_in);
    check(busy, 1'b0);
    @(posedge clk_in);
    ce <= 1'b1;
    rc(`VCO_A_FREQ, 32'h0001_0006);
    $display("loop rate test done");
    stop_test();
  end
endmodule
